// ### pkg/crs_consts.vh
`ifndef CRS_CONSTS_VH
`define CRS_CONSTS_VH
// Register word indices (byte address = index * 4)
`define CRS_IDX_D0      5'h00
`define CRS_IDX_D1      5'h01
`define CRS_IDX_D2      5'h02
`define CRS_IDX_D3      5'h03
`define CRS_IDX_P0      5'h04
`define CRS_IDX_P1      5'h05
`define CRS_IDX_FB      5'h06
`define CRS_IDX_VTB     5'h07
`define CRS_IDX_NIP     5'h08
`define CRS_IDX_USP     5'h09
`define CRS_IDX_ISP     5'h0a
`define CRS_IDX_SB      5'h0b
`define CRS_IDX_FLG     5'h0c
`define CRS_IDX_WDLO    5'h0d
`define CRS_IDX_WDHI    5'h0e
`define CRS_IDX_WPTR    5'h0f
`define CRS_IDX_D0L     5'h10
`define CRS_IDX_D0H     5'h11
`define CRS_IDX_D1L     5'h12
`define CRS_IDX_D1H     5'h13
`define CRS_IDX_LAST    5'h13
// Flag bit positions
`define CRS_F_C         0
`define CRS_F_D         1
`define CRS_F_Z         2
`define CRS_F_S         3
`define CRS_F_B         4
`define CRS_F_O         5
`define CRS_F_I         6
`define CRS_F_U         7
`define CRS_F_IPL_LO    8
`define CRS_F_IPL_HI    10
// Reset values
`define CRS_RST_FLG     11'h000
`define CRS_RST_WORD    16'h0000
`define CRS_RST_NIP     20'h00000
// Software vectors that switch to the interrupt stack
`define CRS_SWI_ISP_MAX 6'h1f
// Address map
`define CRS_SFR0_LO     20'h00000
`define CRS_SFR0_HI     20'h002ff
`define CRS_SFR1_LO     20'h02c00
`define CRS_SFR1_HI     20'h02fff
`define CRS_VEC_LO      20'h0ffdc
`define CRS_VEC_HI      20'h0ffff
`define CRS_RAM_LO      20'h00400
`define CRS_ROM_TOP     20'h0ffff
// Region codes
`define CRS_RG_OTHER    3'h0
`define CRS_RG_SFR      3'h1
`define CRS_RG_VEC      3'h2
`define CRS_RG_ROM      3'h3
`define CRS_RG_RAM      3'h4
`endif

// ### hdl/crs_register_set.v
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "crs_consts.vh"
module crs_register_set #(
  parameter RAM_SIZE = 20'h01800,
  parameter ROM_SIZE = 20'h10000
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Execution unit register port
  input  wire        exWe,
  input  wire [4:0]  exIdx,
  input  wire [31:0] exWdata,
  output reg  [31:0] exRdata,
  // ALU flag update
  input  wire        aluUpd,
  input  wire [3:0]  aluMask,
  input  wire        aluByte,
  input  wire [15:0] aluRes,
  input  wire        aluCarry,
  input  wire        aluOvf,
  // Program flow
  input  wire        pcAdv,
  input  wire [2:0]  pcStep,
  output reg  [19:0] nextInstrPtr,
  output reg  [15:0] activeStackPtr,
  // Interrupts
  input  wire        irqReq,
  input  wire [2:0]  irqLevel,
  input  wire        irqMaskable,
  input  wire        hwAck,
  input  wire        swInt,
  input  wire [5:0]  swVec,
  output reg         irqAccept,
  // Address decode
  input  wire [19:0] memAddr,
  output reg  [2:0]  memRegion,
  output reg         memReserved
);

  // Banked words: data regs, pointers, frame base
  reg [15:0] bankWord [0:13];
  reg [19:0] vectorTableBase;
  reg [15:0] userStackPointer;
  reg [15:0] interruptStackPointer;
  reg [15:0] staticBaseReg;
  reg [10:0] processorStateFlags;

  wire       bankSel   = processorStateFlags[`CRS_F_B];
  wire [3:0] bankOfs   = bankSel ? 4'd7 : 4'd0;
  wire       intEnable = processorStateFlags[`CRS_F_I];
  wire       stackSel  = processorStateFlags[`CRS_F_U];
  wire [2:0] procPriorityLevel =
    processorStateFlags[`CRS_F_IPL_HI:`CRS_F_IPL_LO];

  wire apbAcc = psel & penable & pready;
  wire apbWe  = apbAcc & pwrite;
  wire [4:0] apbIdx = paddr[6:2];
  wire apbBad = (paddr[7] == 1'b1) || (apbIdx > `CRS_IDX_LAST);

  integer k;

  // Index into the banked array for the active bank
  function [3:0] slot;
    input [3:0] ofs;
    input [2:0] i;
    begin
      slot = ofs + {1'b0, i};
    end
  endfunction

  // Sign-extend-free read view of one register index
  function [31:0] readIdx;
    input [4:0]  idx;
    input [15:0] d0, d1, d2, d3, p0, p1, fb;
    input [19:0] vtb, nip;
    input [15:0] user_stack_pointer, interrupt_stack_pointer, sb;
    input [10:0] processor_state_flags;
    begin
      case (idx)
        `CRS_IDX_D0:   readIdx = {16'h0000, d0};
        `CRS_IDX_D1:   readIdx = {16'h0000, d1};
        `CRS_IDX_D2:   readIdx = {16'h0000, d2};
        `CRS_IDX_D3:   readIdx = {16'h0000, d3};
        `CRS_IDX_P0:   readIdx = {16'h0000, p0};
        `CRS_IDX_P1:   readIdx = {16'h0000, p1};
        `CRS_IDX_FB:   readIdx = {16'h0000, fb};
        `CRS_IDX_VTB:  readIdx = {12'h000, vtb};
        `CRS_IDX_NIP:  readIdx = {12'h000, nip};
        `CRS_IDX_USP:  readIdx = {16'h0000, user_stack_pointer};
        `CRS_IDX_ISP:  readIdx = {16'h0000, interrupt_stack_pointer};
        `CRS_IDX_SB:   readIdx = {16'h0000, sb};
        `CRS_IDX_FLG:  readIdx = {21'h000000, processor_state_flags};
        `CRS_IDX_WDLO: readIdx = {d2, d0};
        `CRS_IDX_WDHI: readIdx = {d3, d1};
        `CRS_IDX_WPTR: readIdx = {p1, p0};
        `CRS_IDX_D0L:  readIdx = {24'h000000, d0[7:0]};
        `CRS_IDX_D0H:  readIdx = {24'h000000, d0[15:8]};
        `CRS_IDX_D1L:  readIdx = {24'h000000, d1[7:0]};
        `CRS_IDX_D1H:  readIdx = {24'h000000, d1[15:8]};
        default:       readIdx = 32'h00000000;
      endcase
    end
  endfunction

  // Memory map classification, highest priority first
  function [3:0] regionOf;
    input [19:0] a;
    reg inSfr;
    reg inVec;
    reg inRom;
    reg inRam;
    begin
      inSfr = (a <= `CRS_SFR0_HI) ||
              (a >= `CRS_SFR1_LO && a <= `CRS_SFR1_HI);
      inVec = (a >= `CRS_VEC_LO) && (a <= `CRS_VEC_HI);
      // One extra bit so a full 64-Kbyte ROM cannot wrap to empty
      inRom = (a <= `CRS_ROM_TOP) &&
              (({1'b0, a} + {1'b0, ROM_SIZE}) >
               {1'b0, `CRS_ROM_TOP});
      inRam = ({1'b0, a} >= {1'b0, `CRS_RAM_LO}) &&
              ({1'b0, a} < ({1'b0, `CRS_RAM_LO} + {1'b0, RAM_SIZE}));
      if (inSfr)
        regionOf = {1'b0, `CRS_RG_SFR};
      else if (inVec)
        regionOf = {1'b0, `CRS_RG_VEC};
      else if (inRom)
        regionOf = {1'b0, `CRS_RG_ROM};
      else if (inRam)
        regionOf = {1'b0, `CRS_RG_RAM};
      else
        regionOf = {1'b1, `CRS_RG_OTHER};
    end
  endfunction

  // Active bank view; the idle bank is only held, written by nothing but reset
  wire [15:0] activeWord [0:6];
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : gBank
      localparam [2:0] SLOT = g;
      assign activeWord[g] = bankWord[slot(bankOfs, SLOT)];
    end
  endgenerate

  wire [31:0] apbView = readIdx(apbIdx,
    activeWord[0], activeWord[1], activeWord[2], activeWord[3],
    activeWord[4], activeWord[5], activeWord[6], vectorTableBase,
    nextInstrPtr, userStackPointer, interruptStackPointer,
    staticBaseReg, processorStateFlags);

  wire [31:0] exView = readIdx(exIdx,
    activeWord[0], activeWord[1], activeWord[2], activeWord[3],
    activeWord[4], activeWord[5], activeWord[6], vectorTableBase,
    nextInstrPtr, userStackPointer, interruptStackPointer,
    staticBaseReg, processorStateFlags);

  wire [3:0] next_region = regionOf(memAddr);

  // Result flags in the operand width
  wire resZero = aluByte ? (aluRes[7:0] == 8'h00)
                         : (aluRes == 16'h0000);
  wire resNeg  = aluByte ? aluRes[7] : aluRes[15];

  wire accOk = irqReq && (irqLevel > procPriorityLevel) &&
    (!irqMaskable || intEnable);

  // One write into the register file, shared by both writers
  task writeIdx;
    input [4:0]  idx;
    input [31:0] wd;
    begin
      case (idx)
        `CRS_IDX_D0, `CRS_IDX_D1, `CRS_IDX_D2, `CRS_IDX_D3,
        `CRS_IDX_P0, `CRS_IDX_P1, `CRS_IDX_FB:
          bankWord[slot(bankOfs, idx[2:0])] <= wd[15:0];
        `CRS_IDX_VTB: vectorTableBase <= wd[19:0];
        `CRS_IDX_NIP: nextInstrPtr <= wd[19:0];
        `CRS_IDX_USP: userStackPointer <= wd[15:0];
        `CRS_IDX_ISP: interruptStackPointer <= wd[15:0];
        `CRS_IDX_SB:  staticBaseReg <= wd[15:0];
        `CRS_IDX_FLG: processorStateFlags <= wd[10:0];
        `CRS_IDX_WDLO: begin
          bankWord[slot(bankOfs, 3'd0)] <= wd[15:0];
          bankWord[slot(bankOfs, 3'd2)] <= wd[31:16];
        end
        `CRS_IDX_WDHI: begin
          bankWord[slot(bankOfs, 3'd1)] <= wd[15:0];
          bankWord[slot(bankOfs, 3'd3)] <= wd[31:16];
        end
        `CRS_IDX_WPTR: begin
          bankWord[slot(bankOfs, 3'd4)] <= wd[15:0];
          bankWord[slot(bankOfs, 3'd5)] <= wd[31:16];
        end
        `CRS_IDX_D0L:
          bankWord[slot(bankOfs, 3'd0)][7:0] <= wd[7:0];
        `CRS_IDX_D0H:
          bankWord[slot(bankOfs, 3'd0)][15:8] <= wd[7:0];
        `CRS_IDX_D1L:
          bankWord[slot(bankOfs, 3'd1)][7:0] <= wd[7:0];
        `CRS_IDX_D1H:
          bankWord[slot(bankOfs, 3'd1)][15:8] <= wd[7:0];
        default: ;
      endcase
    end
  endtask

  // APB slave: zero wait states, answer registered
  always @(posedge ref_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & apbBad;
      if (psel & ~penable)
        prdata <= (apbBad | pwrite) ? 32'h00000000 : apbView;
    end
  end

  // Register file; later assignments win, so the ALU, hwAck and swInt
  // flag updates placed last override a same-cycle software write
  always @(posedge ref_clk) begin
    if (rst) begin
      for (k = 0; k < 14; k = k + 1)
        bankWord[k] <= `CRS_RST_WORD;
      vectorTableBase       <= `CRS_RST_NIP;
      nextInstrPtr          <= `CRS_RST_NIP;
      userStackPointer      <= `CRS_RST_WORD;
      interruptStackPointer <= `CRS_RST_WORD;
      staticBaseReg         <= `CRS_RST_WORD;
      processorStateFlags   <= `CRS_RST_FLG;
    end else begin
      if (pcAdv)
        nextInstrPtr <= nextInstrPtr + {17'h00000, pcStep};
      if (apbWe && !pslverr && !apbBad)
        writeIdx(apbIdx, pwdata);
      if (exWe)
        writeIdx(exIdx, exWdata);
      if (aluUpd) begin
        if (aluMask[0])
          processorStateFlags[`CRS_F_C] <= aluCarry;
        if (aluMask[1])
          processorStateFlags[`CRS_F_Z] <= resZero;
        if (aluMask[2])
          processorStateFlags[`CRS_F_S] <= resNeg;
        if (aluMask[3])
          processorStateFlags[`CRS_F_O] <= aluOvf;
      end
      if (hwAck) begin
        processorStateFlags[`CRS_F_I] <= 1'b0;
        processorStateFlags[`CRS_F_U] <= 1'b0;
      end
      if (swInt && swVec <= `CRS_SWI_ISP_MAX)
        processorStateFlags[`CRS_F_U] <= 1'b0;
    end
  end

  // Core-facing views, one cycle behind the registers
  always @(posedge ref_clk) begin
    if (rst) begin
      exRdata        <= 32'h00000000;
      activeStackPtr <= `CRS_RST_WORD;
      irqAccept      <= 1'b0;
      memRegion      <= `CRS_RG_OTHER;
      memReserved    <= 1'b0;
    end else begin
      exRdata <= exView;
      activeStackPtr <= stackSel ?
        userStackPointer : interruptStackPointer;
      // Not gated by hwAck: the core owns acknowledge timing
      irqAccept   <= accOk;
      memRegion   <= next_region[2:0];
      memReserved <= next_region[3];
    end
  end

endmodule

// ### sim/crs_checker.sv
`timescale 1ns/1ps
module crs_checker (
  // Bus side
  input wire        ref_clk,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Core side
  input wire        exWe,
  input wire [4:0]  exIdx,
  input wire [31:0] exRdata,
  input wire        pcAdv,
  input wire [2:0]  pcStep,
  input wire [19:0] nextInstrPtr,
  input wire        irqReq,
  input wire [2:0]  irqLevel,
  input wire        irqAccept,
  input wire [19:0] memAddr,
  input wire [2:0]  memRegion
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_answer; pready ##1 !pready; endsequence
  property p_ready; s_setup |=> s_answer; endproperty
  a_ready: assert property (p_ready)
    else $error("pready not one cycle");
  property p_unmap;
    s_setup and paddr[7] |=> pslverr && prdata == 0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped access not refused");
  property p_nip;
    pcAdv && !exWe && !psel
      |=> nextInstrPtr == $past(nextInstrPtr) + $past(pcStep);
  endproperty
  a_nip: assert property (p_nip)
    else $error("pointer step wrong");
  property p_hold;
    !pcAdv && !exWe && !psel |=> $stable(nextInstrPtr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("pointer moved");
  property p_lvl0; irqReq && irqLevel == 0 |=> !irqAccept; endproperty
  a_lvl0: assert property (p_lvl0)
    else $error("level zero accepted");
  property p_flg; exIdx == 5'h0c |=> exRdata[31:11] == 0; endproperty
  a_flg: assert property (p_flg)
    else $error("flag word too wide");
  property p_sfr; memAddr <= 20'h002ff |=> memRegion == 3'h1; endproperty
  a_sfr: assert property (p_sfr)
    else $error("peripheral window missed");
  property p_vec;
    memAddr >= 20'h0ffdc && memAddr <= 20'h0ffff |=> memRegion == 3'h2;
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector region missed");
  property p_rom;
    memAddr >= 20'h00300 && memAddr <= 20'h02bff |=> memRegion == 3'h3;
  endproperty
  a_rom: assert property (p_rom)
    else $error("program region missed");
endmodule
bind crs_register_set crs_checker u_chk (.ref_clk, .rst, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .exWe, .exIdx, .exRdata, .pcAdv,
  .pcStep, .nextInstrPtr, .irqReq, .irqLevel, .irqAccept, .memAddr,
  .memRegion);

// ### sim/crs_exec_model.sv
`timescale 1ns/1ps
module crs_exec_model (
  // Clock
  input  wire         ref_clk,
  // Register port
  output logic        exWe,
  output logic [4:0]  exIdx,
  output logic [31:0] exWdata,
  input  wire  [31:0] exRdata,
  // Interrupt events
  output logic        hwAck,
  output logic        swInt,
  output logic [5:0]  swVec
);
  initial {exWe, exIdx, exWdata, hwAck, swInt, swVec} = '0;
  task wr(input [4:0] i, input [31:0] d);
    @(posedge ref_clk);
    exWe <= 1'b1;
    exIdx <= i;
    exWdata <= d;
    @(posedge ref_clk);
    exWe <= 1'b0;
  endtask
  // Output is one edge behind the index
  task rd(input [4:0] i, output [31:0] d);
    @(posedge ref_clk);
    exIdx <= i;
    repeat (2) @(posedge ref_clk);
    d = exRdata;
  endtask
  task ev(input hw, input [5:0] v);
    @(posedge ref_clk);
    hwAck <= hw;
    swInt <= !hw;
    swVec <= v;
    @(posedge ref_clk);
    {hwAck, swInt} <= 2'b00;
  endtask
endmodule

// ### sim/tb_crs_register_set.sv
`timescale 1ns/1ps
module tb_crs_register_set;
  logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        exWe, aluUpd, aluCarry, aluOvf, pcAdv, irqReq, irqMaskable;
  logic        hwAck, swInt, irqAccept, memReserved, err, aluByte;
  logic [2:0]  pcStep, irqLevel, memRegion;
  logic [3:0]  aluMask;
  logic [4:0]  exIdx;
  logic [5:0]  swVec;
  logic [7:0]  paddr;
  logic [15:0] aluRes, activeStackPtr;
  logic [19:0] memAddr, nextInstrPtr;
  logic [31:0] pwdata, prdata, exWdata, exRdata, rd, st, v;
  logic [31:0] shadow [0:11];
  int          miscompares, num_checks, i;
  crs_register_set u_crs_register_set (.ref_clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .exWe, .exIdx,
    .exWdata, .exRdata, .aluUpd, .aluMask, .aluByte, .aluRes,
    .aluCarry, .aluOvf, .pcAdv, .pcStep, .nextInstrPtr, .activeStackPtr,
    .irqReq, .irqLevel, .irqMaskable, .hwAck, .swInt, .swVec, .irqAccept,
    .memAddr, .memRegion, .memReserved);
  crs_exec_model u_exec (.ref_clk, .exWe, .exIdx, .exWdata, .exRdata,
    .hwAck, .swInt, .swVec);
  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end
  task test_done;
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("Error %s exp %h got %h", n, e, g);
      miscompares++;
    end
  endtask
  function [31:0] xs;
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    xs = st;
  endfunction
  function [31:0] msk(input int k);
    msk = (k == 7 || k == 8) ? 32'hfffff : 32'hffff;
  endfunction
  function [31:0] expReg(input [19:0] a);
    if (a <= 20'h002ff || (a >= 20'h02c00 && a <= 20'h02fff))
      expReg = 32'h1;
    else if (a >= 20'h0ffdc && a <= 20'h0ffff)
      expReg = 32'h2;
    else if (a <= 20'h0ffff)
      expReg = 32'h3;
    else
      expReg = 32'h8;
  endfunction
  function [31:0] acc(input [31:0] r);
    acc = {31'h0, r[2:0] > r[10:8] && (!r[3] || r[6])};
  endfunction
  task apb(input w, input [5:0] a, input [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'b00};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      test_done;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdc(input string n, input [5:0] a, input [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask
  task alu(input [15:0] r, input c, input o, input b);
    @(posedge ref_clk);
    aluUpd <= 1'b1;
    aluByte <= b;
    aluRes <= r;
    aluCarry <= c;
    aluOvf <= o;
    @(posedge ref_clk);
    aluUpd <= 1'b0;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, aluUpd, aluCarry, aluOvf} = '0;
    {pcAdv, pcStep, irqReq, irqLevel, irqMaskable, memAddr, aluRes} = '0;
    aluMask = 4'hf;
    aluByte = 1'b0;
    st = 32'd45495;
    rst = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    for (i = 0; i < 13; i++) rdc("reset", i[5:0], 32'h0);
    for (i = 0; i < 12; i++) begin
      shadow[i] = xs();
      apb(1'b1, i[5:0], shadow[i]);
    end
    for (i = 0; i < 12; i++) rdc("reg", i[5:0], shadow[i] & msk(i));
    apb(1'b1, 6'h0d, 32'hcafe1234);
    rdc("d2", 6'h02, 32'hcafe);
    apb(1'b1, 6'h0f, 32'h5a5a0f0f);
    rdc("p1", 6'h05, 32'h5a5a);
    apb(1'b1, 6'h11, 32'hab);
    rdc("d0", 6'h00, 32'hab34);
    rdc("unmap", 6'h20, 32'h0);
    chk("err", 32'h1, {31'h0, err});
    apb(1'b1, 6'h0c, 32'h010);
    rdc("bank1", 6'h00, 32'h0);
    apb(1'b1, 6'h00, 32'h7777);
    apb(1'b1, 6'h0c, 32'h000);
    rdc("bank0", 6'h00, 32'hab34);
    alu(16'h0000, 1'b1, 1'b0, 1'b0);
    rdc("zc", 6'h0c, 32'h005);
    alu(16'h8000, 1'b0, 1'b1, 1'b0);
    rdc("so", 6'h0c, 32'h028);
    alu(16'h0100, 1'b0, 1'b0, 1'b1);
    rdc("zb", 6'h0c, 32'h004);
    apb(1'b1, 6'h09, 32'h1111);
    apb(1'b1, 6'h0a, 32'h2222);
    apb(1'b1, 6'h0c, 32'h0c0);
    repeat (2) @(posedge ref_clk);
    chk("usp", 32'h1111, {16'h0, activeStackPtr});
    u_exec.ev(1'b1, 6'h0);
    rdc("ack", 6'h0c, 32'h0);
    chk("isp", 32'h2222, {16'h0, activeStackPtr});
    apb(1'b1, 6'h0c, 32'h080);
    u_exec.ev(1'b0, 6'd32);
    rdc("sw32", 6'h0c, 32'h080);
    u_exec.ev(1'b0, 6'd31);
    rdc("sw31", 6'h0c, 32'h0);
    u_exec.wr(5'h0b, 32'hbeef);
    u_exec.rd(5'h0c, v);
    u_exec.rd(5'h0b, v);
    chk("ex", 32'hbeef, v);
    for (i = 0; i < 16; i++) begin
      v = xs();
      apb(1'b1, 6'h0c, {21'h0, v[10:8], 1'b0, v[6], 6'h0});
      irqReq <= 1'b1;
      irqLevel <= v[2:0];
      irqMaskable <= v[3];
      repeat (2) @(posedge ref_clk);
      chk("irq", acc(v), {31'h0, irqAccept});
      irqReq <= 1'b0;
    end
    apb(1'b1, 6'h08, 32'hffffe);
    pcAdv <= 1'b1;
    pcStep <= 3'd3;
    @(posedge ref_clk);
    pcAdv <= 1'b0;
    rdc("pc", 6'h08, 32'h1);
    for (i = 0; i < 40; i++) begin
      v = xs();
      memAddr <= i < 4 ? 20'h0ffdc + 20'(i * 35)
                       : (i[0] ? {8'h0, v[11:0]} : v[19:0]);
      repeat (2) @(posedge ref_clk);
      chk("region", expReg(memAddr), 32'({memReserved, memRegion}));
    end
    test_done;
  end
endmodule
